// ==== hw/port_flow_control.sv ====
// apb register for one switch port's flow-control selection and status
// assumes a zero-wait apb master, synchronous status inputs and straps
// that are stable for at least one edge after reset is released
//
// Register access over APB is this design's own decision.
`timescale 1ns/100ps
// Behaviour
// - bit 6 enables half-duplex backpressure generation
// - bit 5 reads duplex in use, 1=half
// - bit 4 reads current pause receive enable
// - bit 3 reads current pause transmit enable
// - current pause bits follow manual or negotiated source, both forced off in half duplex
// - bit 2 manual pause detection enable
// - bit 1 manual pause generation enable
// - bit0 low, negotiation on: negotiated result rules
// - bit0 low, negotiation off: manual enables apply
// - bit0 high: manual enables rule in full duplex
// - writes never touch phy advertisement values
// - writable fields reset from their straps
// - current bits reset from strap combination
module port_flow_control
(
  // clock and reset
  input  wire logic                      SYS_CLK,
  input  wire logic                      RSTN,
  // apb slave
  input  wire logic                      PSEL,
  input  wire logic                      PENABLE,
  input  wire logic                      PWRITE,
  input  wire logic [fc_pkg::ADDR_W-1:0] PADDR,
  input  wire logic [fc_pkg::DATA_W-1:0] PWDATA,
  input  wire logic [3:0]                PSTRB,
  output logic      [fc_pkg::DATA_W-1:0] PRDATA,
  output logic                           PREADY,
  output logic                           PSLVERR,
  // live link and negotiation status
  input  wire logic                      AUTONEG_ENABLE,
  input  wire logic                      LINK_HALF_DUPLEX,
  input  wire logic                      AUTONEG_PAUSE_RX,
  input  wire logic                      AUTONEG_PAUSE_TX,
  // configuration straps
  input  wire logic                      BACKPRESSURE_DEFAULT_STRAP,
  input  wire logic                      PAUSE_DEFAULT_STRAP,
  input  wire logic                      SOURCE_SELECT_DEFAULT_STRAP,
  input  wire logic                      AUTONEG_DEFAULT_STRAP,
  input  wire logic                      HALF_DUPLEX_DEFAULT_STRAP,
  // controls to the port mac
  output logic                           BACKPRESSURE_ENABLE,
  output logic                           PAUSE_RX_ENABLE,
  output logic                           PAUSE_TX_ENABLE
);

  typedef struct packed
  {
    fc_pkg::phase_type         phase;
    logic                      backpressure_enable;
    logic                      current_duplex;
    logic                      current_pause_rx_enable;
    logic                      current_pause_tx_enable;
    logic                      pause_rx_enable;
    logic                      pause_tx_enable;
    logic                      flow_source_select;
    logic [fc_pkg::DATA_W-1:0] rdata;
    logic                      bp_out;
  } state_type;

  state_type s_reg;
  state_type s_next;

  logic loading;
  logic addr_hit;
  logic setup_rd;
  logic access_wr;
  logic sel_in;
  logic an_in;
  logic half_in;
  logic man_rx_in;
  logic man_tx_in;
  logic neg_rx_in;
  logic neg_tx_in;
  logic res_rx;
  logic res_tx;

  // packs the visible register image; upper bits stay zero
  function automatic logic [fc_pkg::DATA_W-1:0] pack_image(input state_type s);
    logic [fc_pkg::DATA_W-1:0] v;
    v = fc_pkg::RST_DATA;
    v[fc_pkg::BIT_BP]      = s.backpressure_enable;
    v[fc_pkg::BIT_CUR_DUP] = s.current_duplex;
    v[fc_pkg::BIT_CUR_RX]  = s.current_pause_rx_enable;
    v[fc_pkg::BIT_CUR_TX]  = s.current_pause_tx_enable;
    v[fc_pkg::BIT_RX]      = s.pause_rx_enable;
    v[fc_pkg::BIT_TX]      = s.pause_tx_enable;
    v[fc_pkg::BIT_SEL]     = s.flow_source_select;
    return v;
  endfunction

  // bus decode; only one word is mapped
  assign loading   = (s_reg.phase == fc_pkg::PH_LOAD);
  assign addr_hit  = (PADDR == fc_pkg::FC_OFFSET);
  assign setup_rd  = PSEL & ~PENABLE & ~PWRITE;
  assign access_wr = PSEL & PENABLE & PWRITE & addr_hit;

  // zero-wait slave; unmapped words answer with an error
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~addr_hit;

  // during the load edge the resolver sees the straps, so the status bits
  // start from the strap combination instead of half-settled live inputs
  assign sel_in    = loading ? SOURCE_SELECT_DEFAULT_STRAP : s_reg.flow_source_select;
  assign an_in     = loading ? AUTONEG_DEFAULT_STRAP       : AUTONEG_ENABLE;
  assign half_in   = loading ? HALF_DUPLEX_DEFAULT_STRAP   : LINK_HALF_DUPLEX;
  assign man_rx_in = loading ? PAUSE_DEFAULT_STRAP         : s_reg.pause_rx_enable;
  assign man_tx_in = loading ? PAUSE_DEFAULT_STRAP         : s_reg.pause_tx_enable;
  assign neg_rx_in = loading ? PAUSE_DEFAULT_STRAP         : AUTONEG_PAUSE_RX;
  assign neg_tx_in = loading ? PAUSE_DEFAULT_STRAP         : AUTONEG_PAUSE_TX;

  // the one place that decides manual versus negotiated pause
  pause_resolve u_resolve
  (
    .select_manual (sel_in),
    .autoneg_on    (an_in),
    .half_duplex   (half_in),
    .manual_rx     (man_rx_in),
    .manual_tx     (man_tx_in),
    .negotiated_rx (neg_rx_in),
    .negotiated_tx (neg_tx_in),
    .pause_rx      (res_rx),
    .pause_tx      (res_tx)
  );

  // next state: strap load, status tracking, register write, read capture
  always_comb
  begin
    s_next = s_reg;
    s_next.current_duplex          = half_in;
    s_next.current_pause_rx_enable = res_rx;
    s_next.current_pause_tx_enable = res_tx;
    if (loading)
    begin
      s_next.phase               = fc_pkg::PH_RUN;
      s_next.backpressure_enable = BACKPRESSURE_DEFAULT_STRAP;
      s_next.pause_rx_enable     = PAUSE_DEFAULT_STRAP;
      s_next.pause_tx_enable     = PAUSE_DEFAULT_STRAP;
      s_next.flow_source_select  = SOURCE_SELECT_DEFAULT_STRAP;
    end
    else if (access_wr && PSTRB[fc_pkg::LANE_FIELDS])
    begin
      // only writable fields are stored; no path leads to the phy advertisement
      s_next.backpressure_enable = PWDATA[fc_pkg::BIT_BP];
      s_next.pause_rx_enable     = PWDATA[fc_pkg::BIT_RX];
      s_next.pause_tx_enable     = PWDATA[fc_pkg::BIT_TX];
      s_next.flow_source_select  = PWDATA[fc_pkg::BIT_SEL];
    end
    // read data is captured in the setup cycle so prdata comes from a flop
    if (setup_rd)
    begin
      s_next.rdata = addr_hit ? pack_image(s_reg) : fc_pkg::RST_DATA;
    end
    // backpressure is only meaningful while the link runs half duplex
    s_next.bp_out = s_next.backpressure_enable & half_in;
  end

  // state register; reset holds constants, straps come one edge later
  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      s_reg.phase                   <= fc_pkg::PH_LOAD;
      s_reg.backpressure_enable     <= fc_pkg::RST_FIELD;
      s_reg.current_duplex          <= fc_pkg::RST_FIELD;
      s_reg.current_pause_rx_enable <= fc_pkg::RST_FIELD;
      s_reg.current_pause_tx_enable <= fc_pkg::RST_FIELD;
      s_reg.pause_rx_enable         <= fc_pkg::RST_FIELD;
      s_reg.pause_tx_enable         <= fc_pkg::RST_FIELD;
      s_reg.flow_source_select      <= fc_pkg::RST_FIELD;
      s_reg.rdata                   <= fc_pkg::RST_DATA;
      s_reg.bp_out                  <= fc_pkg::RST_FIELD;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // outputs straight from flops
  assign PRDATA              = s_reg.rdata;
  assign BACKPRESSURE_ENABLE = s_reg.bp_out;
  assign PAUSE_RX_ENABLE     = s_reg.current_pause_rx_enable;
  assign PAUSE_TX_ENABLE     = s_reg.current_pause_tx_enable;

  // checks on the block in its load and run phases
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RSTN);

  logic running;
  assign running = (s_reg.phase == fc_pkg::PH_RUN);

  chk_bp_write: assert property (
    running && access_wr && PSTRB[fc_pkg::LANE_FIELDS]
    |=> s_reg.backpressure_enable == $past(PWDATA[fc_pkg::BIT_BP]) ##1
        BACKPRESSURE_ENABLE == (s_reg.backpressure_enable && $past(LINK_HALF_DUPLEX)))
    else $error("backpressure enable not written or not driven out");

  chk_duplex_track: assert property (
    running |=> s_reg.current_duplex == $past(LINK_HALF_DUPLEX))
    else $error("current duplex does not follow the link");

  chk_half_no_pause: assert property (
    running && LINK_HALF_DUPLEX |=> !PAUSE_RX_ENABLE && !PAUSE_TX_ENABLE)
    else $error("pause left enabled in half duplex");

  chk_manual_select: assert property (
    running && s_reg.flow_source_select && !LINK_HALF_DUPLEX
    |=> PAUSE_RX_ENABLE == $past(s_reg.pause_rx_enable)
        && PAUSE_TX_ENABLE == $past(s_reg.pause_tx_enable))
    else $error("manual selection not applied");

  chk_negotiated_use: assert property (
    running && !s_reg.flow_source_select && AUTONEG_ENABLE && !LINK_HALF_DUPLEX
    |=> PAUSE_RX_ENABLE == $past(AUTONEG_PAUSE_RX)
        && PAUSE_TX_ENABLE == $past(AUTONEG_PAUSE_TX))
    else $error("negotiated pause not applied");

  chk_an_off_manual: assert property (
    running && !s_reg.flow_source_select && !AUTONEG_ENABLE && !LINK_HALF_DUPLEX
    |=> PAUSE_RX_ENABLE == $past(s_reg.pause_rx_enable)
        && PAUSE_TX_ENABLE == $past(s_reg.pause_tx_enable))
    else $error("manual pause not applied with negotiation off");

  chk_read_image: assert property (
    running && setup_rd && addr_hit
    |=> PRDATA[fc_pkg::BIT_CUR_RX] == $past(s_reg.current_pause_rx_enable)
        && PRDATA[fc_pkg::BIT_CUR_TX] == $past(s_reg.current_pause_tx_enable)
        && PRDATA[fc_pkg::BIT_RX] == $past(s_reg.pause_rx_enable))
    else $error("read image does not match state");

  chk_reserved_zero: assert property (
    PSEL && PENABLE && !PWRITE |-> PRDATA[fc_pkg::DATA_W-1:fc_pkg::BIT_BP+1] == 25'h000_0000)
    else $error("reserved bits read non-zero");

  chk_strap_load: assert property (
    loading |=> s_reg.backpressure_enable == $past(BACKPRESSURE_DEFAULT_STRAP)
        && s_reg.pause_rx_enable == $past(PAUSE_DEFAULT_STRAP)
        && s_reg.flow_source_select == $past(SOURCE_SELECT_DEFAULT_STRAP))
    else $error("writable fields not loaded from straps");

  chk_status_strap: assert property (
    loading |=> s_reg.current_duplex == $past(HALF_DUPLEX_DEFAULT_STRAP)
        && (!s_reg.current_duplex || !s_reg.current_pause_tx_enable))
    else $error("status bits not derived from straps");

  chk_ro_status: assert property (
    running && access_wr && (PWDATA[fc_pkg::BIT_CUR_DUP] != LINK_HALF_DUPLEX)
    |=> s_reg.current_duplex == $past(LINK_HALF_DUPLEX))
    else $error("write reached a read-only status bit");

  chk_unmapped_err: assert property (
    PSEL && PENABLE && !addr_hit |-> PSLVERR && PREADY)
    else $error("unmapped access not refused");

  // field writes land on the edge that completes the access
  chk_rx_field: assert property (
    running && access_wr && PSTRB[fc_pkg::LANE_FIELDS]
    |=> s_reg.pause_rx_enable == $past(PWDATA[fc_pkg::BIT_RX]))
    else $error("pause receive enable not written");

  chk_tx_field: assert property (
    running && access_wr && PSTRB[fc_pkg::LANE_FIELDS]
    |=> s_reg.pause_tx_enable == $past(PWDATA[fc_pkg::BIT_TX]))
    else $error("pause transmit enable not written");

  chk_sel_field: assert property (
    running && access_wr && PSTRB[fc_pkg::LANE_FIELDS]
    |=> s_reg.flow_source_select == $past(PWDATA[fc_pkg::BIT_SEL]))
    else $error("source select not written");

  // a write that misses byte lane zero or the mapped word changes nothing
  chk_lane_ignored: assert property (
    running && PSEL && PENABLE && PWRITE && !(addr_hit && PSTRB[fc_pkg::LANE_FIELDS])
    |=> $stable(s_reg.backpressure_enable) && $stable(s_reg.pause_rx_enable)
        && $stable(s_reg.pause_tx_enable) && $stable(s_reg.flow_source_select))
    else $error("ignored write changed a field");

  // backpressure never leaves the block while the link runs full duplex
  chk_full_no_bp: assert property (
    running && !LINK_HALF_DUPLEX |=> !BACKPRESSURE_ENABLE)
    else $error("backpressure driven in full duplex");

  chk_dup_image: assert property (
    running && setup_rd && addr_hit
    |=> PRDATA[fc_pkg::BIT_CUR_DUP] == $past(s_reg.current_duplex)
        && PRDATA[fc_pkg::BIT_BP] == $past(s_reg.backpressure_enable)
        && PRDATA[fc_pkg::BIT_TX] == $past(s_reg.pause_tx_enable)
        && PRDATA[fc_pkg::BIT_SEL] == $past(s_reg.flow_source_select))
    else $error("read image fields do not match state");

  // main scenarios
  cov_manual_write: cover property (running && access_wr ##1 s_reg.flow_source_select);
  cov_negotiated:   cover property (running && !s_reg.flow_source_select
                                    && AUTONEG_ENABLE ##1 PAUSE_RX_ENABLE);
  cov_backpressure: cover property (BACKPRESSURE_ENABLE);
  cov_error_access: cover property (PSLVERR);

endmodule

// ==== hw/fc_pkg.sv ====
// constants and types for the port flow-control register block
// assumes an apb slave with 32-bit data and a 12-bit byte address
package fc_pkg;

  // bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // register byte address
  localparam logic [ADDR_W-1:0] FC_OFFSET = 12'h01a0;

  // field positions inside the register
  localparam int BIT_SEL     = 0;
  localparam int BIT_TX      = 1;
  localparam int BIT_RX      = 2;
  localparam int BIT_CUR_TX  = 3;
  localparam int BIT_CUR_RX  = 4;
  localparam int BIT_CUR_DUP = 5;
  localparam int BIT_BP      = 6;

  // byte lane that carries every writable field
  localparam int LANE_FIELDS = 0;

  // reset values (straps are loaded one edge after release)
  localparam logic              RST_FIELD = 1'b0;
  localparam logic [DATA_W-1:0] RST_DATA  = 32'h0000_0000;

  // one-hot phases of the block
  typedef enum logic [1:0]
  {
    PH_LOAD = 2'b01,
    PH_RUN  = 2'b10
  } phase_type;

endpackage

// ==== hw/pause_resolve.sv ====
// works out which pause directions are really in effect on the port
// assumes all inputs are steady levels in the system clock domain
`timescale 1ns/100ps
module pause_resolve
(
  // source selection
  input  wire logic select_manual,
  input  wire logic autoneg_on,
  input  wire logic half_duplex,
  // manual settings
  input  wire logic manual_rx,
  input  wire logic manual_tx,
  // negotiated result
  input  wire logic negotiated_rx,
  input  wire logic negotiated_tx,
  // resolved result
  output logic      pause_rx,
  output logic      pause_tx
);

  logic use_manual;

  // manual wins when selected or when negotiation is off
  assign use_manual = select_manual | ~autoneg_on;

  // pause frames exist only in full duplex, so half duplex forces both off
  always_comb
  begin
    if (half_duplex)
    begin
      pause_rx = 1'b0;
      pause_tx = 1'b0;
    end
    else if (use_manual)
    begin
      pause_rx = manual_rx;
      pause_tx = manual_tx;
    end
    else
    begin
      pause_rx = negotiated_rx;
      pause_tx = negotiated_tx;
    end
  end

endmodule

// ==== sim/port_flow_control_bench.sv ====
// self-checking bench for the port flow-control register block
// assumes the block answers apb with zero or more waits and straps held steady
`timescale 1ns/100ps
module port_flow_control_bench;
  logic                      clk, rstn, psel, penable, pwrite;
  logic [fc_pkg::ADDR_W-1:0] paddr;
  logic [fc_pkg::DATA_W-1:0] pwdata, prdata, rd;
  logic [3:0]                pstrb;
  logic                      pready, pslverr, er;
  logic                      an_en, half, neg_rx, neg_tx;
  logic                      bp_out, rx_out, tx_out;
  int                        mismatches, tests_run;

  port_flow_control dut_u (.SYS_CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .AUTONEG_ENABLE(an_en), .LINK_HALF_DUPLEX(half),
    .AUTONEG_PAUSE_RX(neg_rx), .AUTONEG_PAUSE_TX(neg_tx), .BACKPRESSURE_DEFAULT_STRAP(1'b1),
    .PAUSE_DEFAULT_STRAP(1'b1), .SOURCE_SELECT_DEFAULT_STRAP(1'b0),
    .AUTONEG_DEFAULT_STRAP(1'b1), .HALF_DUPLEX_DEFAULT_STRAP(1'b0),
    .BACKPRESSURE_ENABLE(bp_out), .PAUSE_RX_ENABLE(rx_out), .PAUSE_TX_ENABLE(tx_out));

  // 100 MHz system clock
  always #5 clk = ~clk;

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t word got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t bit got %b expected %b", $time, got, exp);
    end
  endtask

  // one apb transfer; waits for pready as long as it takes (the watchdog
  // ends a hang), takes the answer at that edge, then releases the bus
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_reg(input logic [11:0] a);
    apb(1'b0, a, 32'h0000_0000, 4'h0);
  endtask

  // status settles one edge after a cause; two edges leave margin for the outputs
  task automatic settle();
    repeat (2) @(posedge clk);
  endtask

  // straps: backpressure on, pause on, negotiation source, full duplex;
  // the live link runs half duplex, so the read captured right after the
  // load edge shows the strap image and the outputs then follow the link
  task automatic t_reset_values();
    rd_reg(fc_pkg::FC_OFFSET);
    chk_word(rd, 32'h0000_005e);
    chk_bit(rx_out, 1'b0);
    chk_bit(tx_out, 1'b0);
    chk_bit(bp_out, 1'b1);
  endtask

  // every combination of source, negotiation, duplex and pause polarity;
  // manual and negotiated values always disagree so the chosen source shows
  task automatic t_modes();
    logic [31:0] exp;
    logic [31:0] wr;
    logic        sel, hd, flip, man, erx, etx;
    for (int i = 0; i < 16; i++)
    begin
      sel  = i[2];
      hd   = i[0];
      flip = i[3];
      an_en <= i[1]; half <= hd; neg_rx <= flip; neg_tx <= ~flip;
      wr = (flip ? 32'h0000_0042 : 32'h0000_0044) | 32'(sel);
      apb(1'b1, fc_pkg::FC_OFFSET, wr, 4'hf);
      settle();
      man = sel | ~i[1];
      erx = ~hd & (man ^ flip);
      etx = ~hd & ~(man ^ flip);
      exp = wr | {26'h0, hd, erx, etx, 3'h0};
      rd_reg(fc_pkg::FC_OFFSET);
      chk_word(rd, exp);
      chk_bit(rx_out, erx);
      chk_bit(tx_out, etx);
      chk_bit(bp_out, hd);
    end
  endtask

  // reserved and status bits ignore writes, reserved read zero
  task automatic t_reserved();
    an_en <= 1'b1; half <= 1'b0;
    apb(1'b1, fc_pkg::FC_OFFSET, 32'hffff_fff9, 4'hf);
    settle();
    rd_reg(fc_pkg::FC_OFFSET);
    chk_word(rd, 32'h0000_0041);
  endtask

  // unmapped address errors, masked lane ignored, backpressure disabled
  task automatic t_refused();
    apb(1'b1, fc_pkg::FC_OFFSET + 12'h004, 32'h0000_0000, 4'hf);
    chk_bit(er, 1'b1);
    rd_reg(fc_pkg::FC_OFFSET + 12'h004);
    chk_word(rd, 32'h0000_0000);
    apb(1'b1, fc_pkg::FC_OFFSET, 32'h0000_0000, 4'he);
    rd_reg(fc_pkg::FC_OFFSET);
    chk_bit(er, 1'b0);
    chk_word(rd, 32'h0000_0041);
    half <= 1'b1;
    apb(1'b1, fc_pkg::FC_OFFSET, 32'h0000_0000, 4'h1);
    settle();
    rd_reg(fc_pkg::FC_OFFSET);
    chk_word(rd, 32'h0000_0020);
    chk_bit(bp_out, 1'b0);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // watchdog: the whole run needs well under a thousand cycles
  initial
  begin
    #100us;
    mismatches++;
    end_of_test();
  end

  initial
  begin
    clk = 1'b0; rstn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0000_0000; pstrb = 4'h0;
    an_en = 1'b1; half = 1'b1; neg_rx = 1'b1; neg_tx = 1'b1;
    mismatches = 0; tests_run = 0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    t_reset_values();
    t_modes();
    t_reserved();
    t_refused();
    end_of_test();
  end
endmodule
